/* File: hdl/bsp_port.sv */
// burst-of-four ddr sram host port: command decode, write capture, read launch
module bsp_port #(
  parameter int ORG_W = bsp_pkg::BSP_ORG_W,
  parameter int FIFO_DEPTH = bsp_pkg::BSP_FIFO_DEPTH
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic input_clk_p_in,
  input wire logic input_clk_n_in,
  input wire logic output_clk_p_in,
  input wire logic output_clk_n_in,
  input wire logic load_n_in,
  input wire logic read_not_write_in,
  input wire logic [bsp_pkg::BSP_AW-1:0] addr_in,
  input wire logic [1:0] burst_word_sel_in,
  input wire logic [bsp_pkg::BSP_SELS-1:0] byte_write_sel_n_in,
  input wire logic [bsp_pkg::BSP_NIBS-1:0] nibble_write_sel_n_in,
  input wire logic [bsp_pkg::BSP_DW-1:0] data_in,
  output logic [bsp_pkg::BSP_DW-1:0] data_out,
  output logic data_oe_out,
  output logic echo_clk_p_out,
  output logic echo_clk_n_out,
  input wire logic [bsp_pkg::BSP_ZW-1:0] impedance_ref_in,
  output logic [bsp_pkg::BSP_ZW-1:0] drive_code_out,
  output logic recal_out,
  output logic rd_req_valid_out,
  output logic [bsp_pkg::BSP_AW-1:0] rd_req_addr_out,
  input wire logic rd_data_valid_in,
  input wire bsp_pkg::bsp_burst_t rd_data_in,
  output logic wr_valid_out,
  output bsp_pkg::bsp_wr_rec_t wr_rec_out,
  input wire logic wr_ready_in,
  output logic wr_drop_out
);
  import bsp_pkg::*;

  typedef struct packed {
    bsp_pins_t pin_s1;
    bsp_pins_t pin_s2;
    bsp_pins_t pin_s3;
    logic [BSP_ZW-1:0] z_s1;
    logic [BSP_ZW-1:0] z_s2;
    logic [BSP_ZW-1:0] drive_code;
    logic [BSP_RECAL_W-1:0] recal_cnt;
    logic recal;
    logic echo_p;
    logic echo_n;
    bsp_wstate_t wstate;
    logic wpend;
    logic [BSP_AW-1:0] pend_addr;
    logic [1:0] pend_start;
    logic [BSP_AW-1:0] waddr;
    logic [1:0] wstart;
    bsp_burst_t wbuf;
    bsp_burst_t wkeep;
    logic push_valid;
    bsp_wr_rec_t rec;
    logic wr_drop;
    logic rd_req;
    logic [BSP_AW-1:0] rd_addr;
    logic [1:0] rd_start;
    logic hold_valid;
    logic [1:0] hold_start;
    bsp_burst_t hold_data;
    bsp_rstate_t rstate;
    logic [1:0] ostart;
    bsp_burst_t obuf;
    bsp_word_t dout;
    logic doe;
  } bsp_port_state_t;

  bsp_port_state_t st;
  bsp_port_state_t next_st;
  bsp_pins_t pins_now;
  logic k_pos;
  logic k_neg;
  logic single;
  logic o_pos;
  logic o_neg;
  logic fifo_in_ready;
  logic launch;
  logic [1:0] cap_slot;
  logic [BSP_DW-1:0] keep_now;
  bsp_word_t launch_word;
  logic echo_src_p;
  logic echo_src_n;

  function automatic logic [1:0] slot_of(input logic [1:0] start, input logic [1:0] beat);
    slot_of = start + beat;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin sampling and edge finding
  assign pins_now = {input_clk_p_in, input_clk_n_in, output_clk_p_in, output_clk_n_in,
    load_n_in, read_not_write_in, addr_in, burst_word_sel_in, byte_write_sel_n_in,
    nibble_write_sel_n_in, data_in};
  assign k_pos = st.pin_s2.kp && !st.pin_s3.kp;
  assign k_neg = st.pin_s2.kn && !st.pin_s3.kn;
  assign single = st.pin_s2.cp && st.pin_s2.cn;
  assign o_pos = single ? k_pos : (st.pin_s2.cp && !st.pin_s3.cp);
  assign o_neg = single ? k_neg : (st.pin_s2.cn && !st.pin_s3.cn);
  assign echo_src_p = single ? st.pin_s2.kp : st.pin_s2.cp;
  assign echo_src_n = single ? st.pin_s2.kn : st.pin_s2.cn;
  assign launch = o_neg && st.hold_valid &&
    (st.rstate == BSP_R_IDLE || st.rstate == BSP_R_TAIL);
  assign launch_word = st.hold_data[st.hold_start];

  always_comb
  begin
    unique case (st.wstate)
      BSP_W_SECOND: cap_slot = slot_of(st.wstart, 2'h1);
      BSP_W_THIRD: cap_slot = slot_of(st.wstart, 2'h2);
      BSP_W_FOURTH: cap_slot = slot_of(st.wstart, 2'h3);
      default: cap_slot = slot_of(st.wstart, 2'h0);
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // lane write enables per data bit
  for (genvar b = 0; b < BSP_DW; b++)
  begin : g_keep
    if (ORG_W == 8 && b < 8)
    begin : g_nib
      assign keep_now[b] = !st.pin_s2.nib_n[b / BSP_NIB_W];
    end
    else if (ORG_W != 8 && b < ORG_W)
    begin : g_byte
      assign keep_now[b] = !st.pin_s2.sel_n[b / BSP_LANE_W];
    end
    else
    begin : g_none
      assign keep_now[b] = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_st = st;
    next_st.pin_s1 = pins_now;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_s3 = st.pin_s2;
    next_st.z_s1 = impedance_ref_in;
    next_st.z_s2 = st.z_s1;
    next_st.echo_p = echo_src_p;
    next_st.echo_n = echo_src_n;
    next_st.recal = 1'b0;
    next_st.rd_req = 1'b0;
    next_st.wr_drop = 1'b0;

    // periodic drive code refresh
    if (st.recal_cnt == BSP_RECAL_LAST)
    begin
      next_st.recal_cnt = '0;
      next_st.recal = 1'b1;
      next_st.drive_code = st.z_s2;
    end
    else
    begin
      next_st.recal_cnt = BSP_RECAL_W'(st.recal_cnt + 1'b1);
    end

    // write capture
    unique case (st.wstate)
      BSP_W_IDLE:
      begin
        if (st.wpend)
        begin
          next_st.wpend = 1'b0;
          next_st.waddr = st.pend_addr;
          next_st.wstart = st.pend_start;
          next_st.wstate = BSP_W_FIRST;
        end
      end
      BSP_W_FIRST:
      begin
        if (k_pos)
        begin
          next_st.wbuf[cap_slot] = st.pin_s2.data;
          next_st.wkeep[cap_slot] = keep_now;
          next_st.wstate = BSP_W_SECOND;
        end
      end
      BSP_W_SECOND:
      begin
        if (k_neg)
        begin
          next_st.wbuf[cap_slot] = st.pin_s2.data;
          next_st.wkeep[cap_slot] = keep_now;
          next_st.wstate = BSP_W_THIRD;
        end
      end
      BSP_W_THIRD:
      begin
        if (k_pos)
        begin
          next_st.wbuf[cap_slot] = st.pin_s2.data;
          next_st.wkeep[cap_slot] = keep_now;
          next_st.wstate = BSP_W_FOURTH;
        end
      end
      BSP_W_FOURTH:
      begin
        if (k_neg)
        begin
          next_st.wbuf[cap_slot] = st.pin_s2.data;
          next_st.wkeep[cap_slot] = keep_now;
          next_st.wstate = BSP_W_IDLE;
        end
      end
      default:
      begin
        next_st.wstate = BSP_W_IDLE;
      end
    endcase

    // hand the finished burst to the fifo
    if (st.push_valid && fifo_in_ready)
    begin
      next_st.push_valid = 1'b0;
    end
    if (st.wstate == BSP_W_FOURTH && k_neg)
    begin
      next_st.push_valid = 1'b1;
      next_st.rec.addr = st.waddr;
      next_st.rec.data = next_st.wbuf;
      next_st.rec.keep = next_st.wkeep;
    end

    // command decode at positive input clock rise
    if (k_pos && !st.pin_s2.load_n)
    begin
      if (st.pin_s2.read_not_write)
      begin
        next_st.rd_req = 1'b1;
        next_st.rd_addr = st.pin_s2.addr;
        next_st.rd_start = (ORG_W >= 18) ? st.pin_s2.burst_word_sel : BSP_WORD_FIRST;
      end
      else if (fifo_in_ready && !st.wpend)
      begin
        next_st.wpend = 1'b1;
        next_st.pend_addr = st.pin_s2.addr;
        next_st.pend_start = (ORG_W >= 18) ? st.pin_s2.burst_word_sel : BSP_WORD_FIRST;
      end
      else
      begin
        next_st.wr_drop = 1'b1;
      end
    end

    // read launch on output clock rises
    unique case (st.rstate)
      BSP_R_IDLE, BSP_R_TAIL:
      begin
        if (launch)
        begin
          next_st.obuf = st.hold_data;
          next_st.ostart = st.hold_start;
          next_st.dout = launch_word;
          next_st.doe = 1'b1;
          next_st.hold_valid = 1'b0;
          next_st.rstate = BSP_R_B1;
        end
        else if (o_neg)
        begin
          next_st.doe = 1'b0;
          next_st.rstate = BSP_R_IDLE;
        end
      end
      BSP_R_B1:
      begin
        if (o_pos)
        begin
          next_st.dout = st.obuf[slot_of(st.ostart, 2'h1)];
          next_st.rstate = BSP_R_B2;
        end
      end
      BSP_R_B2:
      begin
        if (o_neg)
        begin
          next_st.dout = st.obuf[slot_of(st.ostart, 2'h2)];
          next_st.rstate = BSP_R_B3;
        end
      end
      BSP_R_B3:
      begin
        if (o_pos)
        begin
          next_st.dout = st.obuf[slot_of(st.ostart, 2'h3)];
          next_st.rstate = BSP_R_TAIL;
        end
      end
      default:
      begin
        next_st.doe = 1'b0;
        next_st.rstate = BSP_R_IDLE;
      end
    endcase

    // array read answer, set wins over the launch clear
    if (rd_data_valid_in)
    begin
      next_st.hold_valid = 1'b1;
      next_st.hold_data = rd_data_in;
      next_st.hold_start = st.rd_start;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      st <= '0;
    end
    else if (ce_in)
    begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write record fifo
  bsp_fifo #(
    .W($bits(bsp_wr_rec_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .in_valid_in(st.push_valid),
    .in_data_in(st.rec),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(wr_valid_out),
    .out_data_out(wr_rec_out),
    .out_ready_in(wr_ready_in)
  );

  assign data_out = st.dout;
  assign data_oe_out = st.doe;
  assign echo_clk_p_out = st.echo_p;
  assign echo_clk_n_out = st.echo_n;
  assign drive_code_out = st.drive_code;
  assign recal_out = st.recal;
  assign rd_req_valid_out = st.rd_req;
  assign rd_req_addr_out = st.rd_addr;
  assign wr_drop_out = st.wr_drop;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  logic [BSP_RECAL_W:0] gap;
  logic gap_armed;

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      gap <= '0;
      gap_armed <= 1'b0;
    end
    else if (ce_in)
    begin
      gap <= st.recal ? '0 : (BSP_RECAL_W + 1)'(gap + 1'b1);
      gap_armed <= gap_armed || st.recal;
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in || !ce_in);

  oe_needs_read_a: assert property (data_oe_out |-> st.rstate != BSP_R_IDLE)
    else $error("data pins driven without a read");
  echo_running_a: assert property (1'b1 |=> echo_clk_p_out == $past(echo_src_p)
    && echo_clk_n_out == $past(echo_src_n))
    else $error("echo clocks do not follow the selected clocks");
  powerup_hiz_a: assert property (@(posedge clock_in) disable iff (1'b0)
    reset_in |=> !data_oe_out)
    else $error("data pins not floating after reset");
  recal_period_a: assert property (recal_out && gap_armed |-> gap == BSP_RECAL_LAST)
    else $error("drive code refresh period wrong");
  write_sample_a: assert property (st.wstate == BSP_W_SECOND && k_neg
    |=> st.wbuf[$past(cap_slot)] == $past(st.pin_s2.data))
    else $error("write word not taken on negative input clock");
  lane_gate_a: assert property (ORG_W == 36 && st.wstate == BSP_W_FIRST && k_pos
    |=> st.wkeep[$past(cap_slot)][35:27] == {9{!$past(st.pin_s2.sel_n[3])}})
    else $error("byte lane three not gated by its select");
  nibble_gate_a: assert property (ORG_W == 8 && st.wstate == BSP_W_THIRD && k_pos
    |=> st.wkeep[$past(cap_slot)][7:4] == {4{!$past(st.pin_s2.nib_n[1])}})
    else $error("upper nibble not gated by its select");
  read_load_a: assert property (k_pos && !st.pin_s2.load_n
    && st.pin_s2.read_not_write
    |=> rd_req_valid_out && rd_req_addr_out == $past(st.pin_s2.addr))
    else $error("read not started with sampled address");
  write_load_a: assert property (k_pos && !st.pin_s2.load_n && !st.pin_s2.read_not_write
    && fifo_in_ready && !st.wpend && st.wstate == BSP_W_IDLE
    |=> st.wpend ##1 st.wstate == BSP_W_FIRST)
    else $error("write not started");
  no_new_op_a: assert property (k_pos && st.pin_s2.load_n && st.wstate == BSP_W_IDLE
    && !st.wpend |=> !rd_req_valid_out && !st.wpend)
    else $error("operation started with load_n high");
  burst_wrap_a: assert property (launch
    |=> data_oe_out && data_out == $past(launch_word))
    else $error("first read word not the addressed word");
  tail_hiz_a: assert property (st.rstate == BSP_R_TAIL && o_neg && !st.hold_valid
    |=> !data_oe_out && st.rstate == BSP_R_IDLE)
    else $error("data pins not released after read");
  burst_order_a: assert property (st.rstate == BSP_R_B1 && !o_pos
    |=> st.rstate == BSP_R_B1)
    else $error("second read word left off its output clock edge");

  write_burst_c: cover property (st.wstate == BSP_W_FOURTH && k_neg);
  read_burst_c: cover property (launch ##[1:200] st.rstate == BSP_R_TAIL);
  single_read_c: cover property (single && launch);
  write_drop_c: cover property (wr_drop_out);

endmodule // bsp_port

/* File: inc/bsp_pkg.sv */
// shared constants and types for the burst-of-four ddr sram host port
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - data pins driven only while read data is being presented, else high impedance
// - both echo clocks run at all times, even while data pins float; held low while reset_in is high
// - data pins come out of reset in high impedance
// - output drive code refreshed from impedance reference every 1024 clock cycles
// - write data sampled on positive and negative input clock rises during writes
// - read data follows output clocks, or input clocks when both output clocks high
// - no new read or load_n high: finish current read, then float data pins
// - write selects sampled with their data; deselected bytes stay unchanged
// - byte selects 0..3 gate data lanes 8:0, 17:9, 26:18, 35:27
// - 8-bit organisation: nibble selects gate bits 3:0 and 7:4
// - address sampled only at positive input clock rise when an operation starts
// - 18/36-bit organisations: burst_word_sel picks the starting word of the burst
// - load_n low at positive input clock rise starts a four-word burst; a write is dropped while the fifo is full or a write is pending
// - load_n high: operations under way complete, no new one starts
// - read_not_write high means read, low means write, ignored when load_n high
// - burst advances linearly and wraps inside the four-word group
// - read words leave on negative, positive, negative, positive output clock rises
package bsp_pkg;

  localparam int BSP_DW = 36;
  localparam int BSP_AW = 17;
  localparam int BSP_WORDS = 4;
  localparam int BSP_SELS = 4;
  localparam int BSP_NIBS = 2;
  localparam int BSP_LANE_W = 9;
  localparam int BSP_NIB_W = 4;
  localparam int BSP_ZW = 6;
  localparam int BSP_ORG_W = 36;
  localparam int BSP_FIFO_DEPTH = 32;
  localparam int BSP_RECAL_CYCLES = 1024;
  localparam int BSP_RECAL_W = $clog2(BSP_RECAL_CYCLES);
  localparam logic [BSP_RECAL_W-1:0] BSP_RECAL_LAST = BSP_RECAL_W'(BSP_RECAL_CYCLES - 1);
  localparam logic [1:0] BSP_WORD_FIRST = 2'h0;

  typedef logic [BSP_DW-1:0] bsp_word_t;
  typedef logic [BSP_WORDS-1:0][BSP_DW-1:0] bsp_burst_t;

  // pin group sampled from the controller side
  typedef struct packed {
    logic kp;
    logic kn;
    logic cp;
    logic cn;
    logic load_n;
    logic read_not_write;
    logic [BSP_AW-1:0] addr;
    logic [1:0] burst_word_sel;
    logic [BSP_SELS-1:0] sel_n;
    logic [BSP_NIBS-1:0] nib_n;
    bsp_word_t data;
  } bsp_pins_t;

  // one completed write burst handed to the array side
  typedef struct packed {
    logic [BSP_AW-1:0] addr;
    bsp_burst_t data;
    bsp_burst_t keep;
  } bsp_wr_rec_t;

  typedef enum logic [2:0] {
    BSP_W_IDLE = 3'h0,
    BSP_W_FIRST = 3'h1,
    BSP_W_SECOND = 3'h2,
    BSP_W_THIRD = 3'h3,
    BSP_W_FOURTH = 3'h4
  } bsp_wstate_t;

  typedef enum logic [2:0] {
    BSP_R_IDLE = 3'h0,
    BSP_R_B1 = 3'h1,
    BSP_R_B2 = 3'h2,
    BSP_R_B3 = 3'h3,
    BSP_R_TAIL = 3'h4
  } bsp_rstate_t;

endpackage

/* File: hdl/bsp_fifo.sv */
// write record fifo between the pin side and the array side
module bsp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  import bsp_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } bsp_fifo_state_t;

  bsp_fifo_state_t st;
  bsp_fifo_state_t next_st;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_out = st.count != CNT_FULL;
  assign out_valid_out = st.count != '0;
  assign out_data_out = mem[st.rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wr_ptr = (st.wr_ptr == PTR_LAST) ? '0 : PW'(st.wr_ptr + 1'b1);
    end
    if (pop)
    begin
      next_st.rd_ptr = (st.rd_ptr == PTR_LAST) ? '0 : PW'(st.rd_ptr + 1'b1);
    end
    if (push && !pop)
    begin
      next_st.count = CW'(st.count + 1'b1);
    end
    else if (pop && !push)
    begin
      next_st.count = CW'(st.count - 1'b1);
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      st <= '0;
    end
    else if (ce_in)
    begin
      st <= next_st;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (ce_in && push)
    begin
      mem[st.wr_ptr] <= in_data_in;
    end
  end

endmodule // bsp_fifo

/* File: verif/bsp_ctrl_model.sv */
// memory controller model: input and output clock pairs, commands, write bursts
module bsp_ctrl_model
  import bsp_pkg::*;
(
  input wire logic clock_in,
  input wire logic single_in,
  output logic kp_out,
  output logic kn_out,
  output logic cp_out,
  output logic cn_out,
  output logic load_n_out,
  output logic rnw_out,
  output logic [BSP_AW-1:0] addr_out,
  output logic [1:0] bws_out,
  output logic [BSP_SELS-1:0] sel_n_out,
  output logic [BSP_DW-1:0] data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cr = 1'b0;
  initial
  begin
    kp_out = 1'b0;
    load_n_out = 1'b1;
    rnw_out = 1'b0;
    addr_out = '0;
    bws_out = '0;
    sel_n_out = '1;
    data_out = '0;
    #1.7;
    forever #40 kp_out = ~kp_out;
  end
  initial
  begin
    #13.3;
    forever #40 cr = ~cr;
  end
  assign kn_out = ~kp_out;
  assign cp_out = single_in | cr;
  assign cn_out = single_in | ~cr;
  ////////////////////////////////////////////////////////////////////////////////
  // one command, two input clock periods long for a read and four for a write, so commands never crowd
  task automatic cmd(input logic ld_n, input logic rnw, input logic [BSP_AW-1:0] a,
    input logic [1:0] b, input bsp_burst_t w, input logic [3:0][BSP_SELS-1:0] s);
    @(posedge kp_out);
    #20;
    @(posedge clock_in);
    load_n_out <= ld_n;
    rnw_out <= rnw;
    addr_out <= a;
    bws_out <= b;
    @(posedge kp_out);
    #20;
    @(posedge clock_in);
    load_n_out <= 1'b1;
    rnw_out <= ~rnw;
    addr_out <= ~a;
    if (!ld_n && !rnw)
    begin
      for (int i = 0; i < 4; i++)
      begin
        data_out <= w[i];
        sel_n_out <= s[i];
        if (i % 2 == 0)
          @(posedge kp_out);
        else
          @(posedge kn_out);
        #20;
        @(posedge clock_in);
      end
      data_out <= ~data_out;
      sel_n_out <= ~sel_n_out;
    end
  endtask
endmodule // bsp_ctrl_model

/* File: verif/bsp_port_tb.sv */
// self-checking bench for the burst-of-four sram host port
module bsp_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import bsp_pkg::*;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic single = 1'b0;
  logic kp, kn, cp, cn, load_n, rnw, oe, ecp, ecn, recal, rd_req, wr_valid, wr_drop;
  logic rd_valid = 1'b0;
  logic wr_ready = 1'b1;
  logic [BSP_AW-1:0] addr, rd_addr;
  logic [1:0] bws;
  logic [BSP_SELS-1:0] sel_n;
  logic [BSP_NIBS-1:0] nib_n = '0;
  logic [BSP_DW-1:0] din, dout;
  logic [BSP_ZW-1:0] zref = 6'h15;
  logic [BSP_ZW-1:0] code;
  bsp_burst_t rd_data = '0;
  bsp_wr_rec_t wr_rec;
  logic wr_valid8;
  bsp_wr_rec_t wr_rec8;
  logic [31:0] seed = 32'h1F1E8199;
  int errors = 0;
  int check_count = 0;
  int drops = 0;
  int reqs = 0;
  bsp_wr_rec_t wq[$];
  bsp_wr_rec_t wq8[$];
  bsp_word_t rq[$];
  always #2 clock_in = ~clock_in;
  bsp_ctrl_model ctrl (.clock_in(clock_in), .single_in(single), .kp_out(kp), .kn_out(kn),
    .cp_out(cp), .cn_out(cn), .load_n_out(load_n), .rnw_out(rnw), .addr_out(addr),
    .bws_out(bws), .sel_n_out(sel_n), .data_out(din));
  bsp_port dut (.clock_in(clock_in), .reset_in(reset_in), .ce_in(1'b1),
    .input_clk_p_in(kp), .input_clk_n_in(kn), .output_clk_p_in(cp), .output_clk_n_in(cn),
    .load_n_in(load_n), .read_not_write_in(rnw), .addr_in(addr), .burst_word_sel_in(bws),
    .byte_write_sel_n_in(sel_n), .nibble_write_sel_n_in(nib_n), .data_in(din),
    .data_out(dout), .data_oe_out(oe), .echo_clk_p_out(ecp), .echo_clk_n_out(ecn),
    .impedance_ref_in(zref), .drive_code_out(code), .recal_out(recal),
    .rd_req_valid_out(rd_req), .rd_req_addr_out(rd_addr), .rd_data_valid_in(rd_valid),
    .rd_data_in(rd_data), .wr_valid_out(wr_valid), .wr_rec_out(wr_rec),
    .wr_ready_in(wr_ready), .wr_drop_out(wr_drop));
  // 8-bit organisation on the same pins, for the nibble selects
  bsp_port #(.ORG_W(8)) dut8 (.clock_in(clock_in), .reset_in(reset_in), .ce_in(1'b1),
    .input_clk_p_in(kp), .input_clk_n_in(kn), .output_clk_p_in(cp), .output_clk_n_in(cn),
    .load_n_in(load_n), .read_not_write_in(rnw), .addr_in(addr), .burst_word_sel_in(bws),
    .byte_write_sel_n_in(sel_n), .nibble_write_sel_n_in(nib_n), .data_in(din),
    .data_out(), .data_oe_out(), .echo_clk_p_out(), .echo_clk_n_out(),
    .impedance_ref_in(zref), .drive_code_out(), .recal_out(),
    .rd_req_valid_out(), .rd_req_addr_out(), .rd_data_valid_in(rd_valid),
    .rd_data_in(rd_data), .wr_valid_out(wr_valid8), .wr_rec_out(wr_rec8),
    .wr_ready_in(wr_ready), .wr_drop_out());
  ////////////////////////////////////////////////////////////////////////////////
  // monitors of the array side and the data pins
  always @(posedge clock_in)
  begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      wq.push_back(wr_rec);
    if (wr_valid8 === 1'b1 && wr_ready === 1'b1)
      wq8.push_back(wr_rec8);
    if (wr_drop === 1'b1)
      drops++;
    if (rd_req === 1'b1)
      reqs++;
    if (oe === 1'b1 && (rq.size() == 0 || dout !== rq[$]))
      rq.push_back(dout);
  end
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic void roll(output logic [63:0] r);
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    r[31:0] = seed;
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    r[63:32] = seed;
  endfunction
  function automatic bsp_burst_t exp_keep(input logic [1:0] b, input logic [3:0][3:0] s);
    bsp_burst_t k = '0;
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < BSP_SELS; j++)
        k[2'(b + i)][j*BSP_LANE_W +: BSP_LANE_W] = {BSP_LANE_W{~s[i][j]}};
    return k;
  endfunction
  task automatic check(input string what, input logic [319:0] e, input logic [319:0] g);
    check_count++;
    if (e !== g)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // one write burst with expected record worked out from the selects
  task automatic do_write(input logic [1:0] b, input logic [3:0][3:0] s);
    logic [63:0] r;
    logic [BSP_AW-1:0] a;
    bsp_burst_t w, e, k, k8;
    bsp_wr_rec_t g, g8;
    roll(r);
    a = r[BSP_AW-1:0];
    for (int i = 0; i < 4; i++)
    begin
      roll(r);
      w[i] = r[BSP_DW-1:0];
      e[2'(b + i)] = w[i];
    end
    k = exp_keep(b, s);
    wq.delete();
    wq8.delete();
    rq.delete();
    ctrl.cmd(1'b0, 1'b0, a, b, w, s);
    for (int n = 0; n < 100 && wq.size() == 0; n++)
      @(posedge clock_in);
    g = (wq.size() > 0) ? wq.pop_front() : '0;
    g8 = (wq8.size() > 0) ? wq8.pop_front() : '0;
    k8 = {4{28'h0, {4{~nib_n[1]}}, {4{~nib_n[0]}}}};
    check("nibble address", a, g8.addr);
    check("nibble keep", k8, g8.keep);
    check("nibble data", w & k8, g8.data & g8.keep);
    check("write address", a, g.addr);
    check("write keep", k, g.keep);
    check("write data", e & k, g.data & k);
    check("write slots", e & k, g.data & g.keep);
    check("oe during write", 0, rq.size());
  endtask
  // one read: request, array answer, four words on the pins, then float
  task automatic do_read(input logic [1:0] b);
    logic [63:0] r;
    logic [BSP_AW-1:0] a;
    bsp_burst_t d;
    roll(r);
    a = r[BSP_AW-1:0];
    for (int i = 0; i < 4; i++)
    begin
      roll(r);
      d[i] = r[BSP_DW-1:0];
    end
    reqs = 0;
    rq.delete();
    ctrl.cmd(1'b0, 1'b1, a, b, '0, '1);
    check("read requests", 1, reqs);
    check("read address", a, rd_addr);
    @(posedge clock_in);
    rd_data <= d;
    rd_valid <= 1'b1;
    @(posedge clock_in);
    rd_valid <= 1'b0;
    for (int n = 0; n < 200 && !(rq.size() > 0 && oe === 1'b0); n++)
      @(posedge clock_in);
    check("read word count", 4, rq.size());
    for (int i = 0; i < 4 && i < rq.size(); i++)
      check("read word", d[2'(b + i)], rq[i]);
    check("oe after read", 0, oe);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    logic [63:0] r;
    int n;
    int hi;
    logic [3:0][3:0] s;
    wait_cycles(3);
    reset_in <= 1'b0;
    wait_cycles(4);
    check("oe after reset", 0, oe);
    for (int m = 0; m < 2; m++)
    begin
      single <= m[0];
      n = 0;
      hi = 0;
      wait_cycles(10);
      for (int c = 0; c < 100; c++)
      begin
        @(posedge clock_in);
        n += (ecp !== ecn) ? 1 : 0;
        hi += (ecp === 1'b1) ? 1 : 0;
      end
      check("echo opposite", 100, n);
      check("echo toggles", 1, hi > 0 && hi < 100);
      check("oe idle", 0, oe);
    end
    $display("echo test done");
    for (n = 0; n < 1100 && recal !== 1'b1; n++)
      @(posedge clock_in);
    @(posedge clock_in);
    check("drive code", zref, code);
    roll(r);
    zref <= r[BSP_ZW-1:0];
    for (n = 1; n < 1100 && recal !== 1'b1; n++)
      @(posedge clock_in);
    check("recal spacing", 1024, n);
    @(posedge clock_in);
    check("drive code new", zref, code);
    $display("recal test done");
    for (int t = 0; t < 8; t++)
    begin
      roll(r);
      s = (t == 0) ? 16'h0 : (t == 1) ? 16'hFFFF : r[15:0];
      @(posedge clock_in);
      nib_n <= r[19:18];
      single <= r[22];
      do_write((t == 2) ? 2'h3 : r[17:16], s);
      do_read((t == 3) ? 2'h3 : r[21:20]);
    end
    $display("burst test done");
    for (int m = 0; m < 2; m++)
    begin
      reqs = 0;
      wq.delete();
      ctrl.cmd(1'b1, m[0], '0, 2'h0, '0, '0);
      wait_cycles(60);
      check("deselect requests", 0, reqs);
      check("deselect records", 0, wq.size());
    end
    $display("deselect test done");
    @(posedge clock_in);
    wr_ready <= 1'b0;
    drops = 0;
    for (int m = 0; m < 33; m++)
    begin
      roll(r);
      ctrl.cmd(1'b0, 1'b0, r[BSP_AW-1:0], r[18:17], '0, '0);
    end
    wait_cycles(40);
    check("full drops", 1, drops);
    wq.delete();
    wr_ready <= 1'b1;
    wait_cycles(100);
    check("drained records", 32, wq.size());
    check("fifo empty", 0, wr_valid);
    $display("fifo test done");
    wrap_up();
  end
  initial
  begin
    #200us;
    errors++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule // bsp_port_tb
